// ==== src/cbs_consts.svh ====
// bus cycle sequencer constants
// Contract
// - indexed byte read: four cycles, dummy FFFF
// - indexed 16-bit load/store: five cycles
// - read-modify-write: six cycles, dummy, write back
// - test-memory sixth cycle reads FFFF instead
// - indexed 16-bit compare/add/sub: six cycles
// - indexed call: six cycles, stack return address
// - simple inherent ops: two read cycles
// - add B to index: three cycles
// - push accumulator: three cycles, write stack
// - pull accumulator: four read cycles
// - push index four cycles, pull five
// - subroutine return: five read cycles
// - interrupt return: ten read cycles
// - multiply: ten cycles, dummy FFFF reads
// - software interrupt: stack all, vector FFFA/FFFB
// - wait op holds bus at stack minus seven
// - extended jump: three cycles
// - extended byte read: four cycles
// - extended accumulator store: four cycles
// - extended 16-bit load/store: five cycles
// - extended 16-bit compare/add/sub: six cycles
// - extended call: six cycles
// - branches three cycles, relative call six
// - direct accumulator store: three cycles
`ifndef CBS_CONSTS_SVH
`define CBS_CONSTS_SVH

`define CBS_ADDR_DUMMY      16'hFFFF
`define CBS_ADDR_IDLE       16'hFFFF
`define CBS_ADDR_VEC_HI     16'hFFFA
`define CBS_ADDR_VEC_LO     16'hFFFB
`define CBS_WAIT_SP_DELTA   5'h19
`define CBS_RET_OFS_INT     16'h0001
`define CBS_RET_OFS_SHORT   16'h0002
`define CBS_RET_OFS_EXT     16'h0003
`define CBS_REL_BASE_OFS    16'h0002
`define CBS_MEM_START       4'h3
`define CBS_MEM_START_DIR   4'h2
`define CBS_STACK_LAST      4'h8
`define CBS_STEP_WAIT       4'h9
`define CBS_STEP_VEC_HI     4'hA
`define CBS_STEP_VEC_LO     4'hB
`define CBS_STEP_PULL_LAST  4'h4
`define CBS_STEP_RTI_LAST   4'h9
`define CBS_MUL_CYCLES      10

`endif

// ==== src/cbs_pkg.sv ====
// types shared by the bus cycle sequencer
package cbs_pkg;
   typedef enum logic [4:0] {
      CBS_K_SIMPLE, CBS_K_ABX, CBS_K_PUSH_ACC, CBS_K_PULL_ACC, CBS_K_PUSH_IDX,
      CBS_K_PULL_IDX, CBS_K_RTS, CBS_K_RTI, CBS_K_MUL, CBS_K_SWI, CBS_K_WAI,
      CBS_K_READ, CBS_K_STORE, CBS_K_LOAD16, CBS_K_STORE16, CBS_K_RMW,
      CBS_K_CMP16, CBS_K_CALL, CBS_K_JUMP, CBS_K_BRANCH
   } cbs_kind_t;

   typedef enum logic [2:0] {
      CBS_M_INH, CBS_M_DIR, CBS_M_IDX, CBS_M_EXT, CBS_M_REL
   } cbs_mode_t;

   typedef enum logic [2:0] {
      CBS_B_PC, CBS_B_DUMMY, CBS_B_EA, CBS_B_SP, CBS_B_VEC_HI, CBS_B_VEC_LO
   } cbs_base_t;

   typedef enum logic [3:0] {
      CBS_D_NONE, CBS_D_RETL, CBS_D_RETH, CBS_D_XL, CBS_D_XH, CBS_D_ACCA,
      CBS_D_ACCB, CBS_D_ACC, CBS_D_CCR, CBS_D_WORDH, CBS_D_WORDL, CBS_D_NEWOP
   } cbs_dsel_t;
endpackage

// ==== src/cbs_ea_calc.sv ====
// effective address of the memory operand
`timescale 1ns/1ps
`default_nettype none
`include "cbs_consts.svh"
module cbs_ea_calc (
   input  wire cbs_pkg::cbs_mode_t mode,     // addressing mode
   input  wire logic [7:0]         byte1,    // first operand byte
   input  wire logic [7:0]         byte2,    // second operand byte
   input  wire logic [15:0]        idx,      // index register
   input  wire logic [15:0]        pc,       // opcode address
   output logic [15:0]             ea        // effective address
);
   wire [15:0] idxEa = idx + {8'h00, byte1};
   wire [15:0] extEa = {byte1, byte2};
   wire [15:0] dirEa = {8'h00, byte1};
   // branch offset is signed, counted from the next opcode
   wire [15:0] relEa = pc + `CBS_REL_BASE_OFS + {{8{byte1[7]}}, byte1};

   assign ea = (mode == cbs_pkg::CBS_M_IDX) ? idxEa :
               (mode == cbs_pkg::CBS_M_EXT) ? extEa :
               (mode == cbs_pkg::CBS_M_DIR) ? dirEa :
               (mode == cbs_pkg::CBS_M_REL) ? relEa : `CBS_ADDR_DUMMY;
endmodule
`default_nettype wire

// ==== src/cbs_bus_sequencer.sv ====
// cycle-by-cycle bus sequencer of the cpu core
`timescale 1ns/1ps
`default_nettype none
`include "cbs_consts.svh"
module cbs_bus_sequencer #(
   parameter int MUL_CYCLES = `CBS_MUL_CYCLES
) (
   input  wire logic               clk_sys,           // core clock
   input  wire logic               rst_n,             // async reset
   input  wire logic               start,             // begin instruction
   input  wire cbs_pkg::cbs_kind_t opKind,            // instruction class
   input  wire cbs_pkg::cbs_mode_t addrMode,          // addressing mode
   input  wire logic               isTst,             // test-memory op
   input  wire logic               accSelB,           // acc B for store/push
   input  wire logic [15:0]        pcIn,              // opcode address
   input  wire logic [15:0]        spIn,              // stack pointer
   input  wire logic [15:0]        idxIn,             // index register
   input  wire logic [7:0]         accAIn,            // accumulator A
   input  wire logic [7:0]         accBIn,            // accumulator B
   input  wire logic [7:0]         ccrIn,             // condition codes
   input  wire logic [15:0]        storeWordIn,       // 16-bit store data
   input  wire logic [7:0]         rmwDataIn,         // new operand byte
   input  wire logic               wakeIn,            // interrupt ends wait
   input  wire logic [7:0]         busDin,            // data bus in
   output logic [15:0]             addressBusValue_ff, // address bus
   output logic                    busRw_ff,          // 1 read, 0 write
   output logic [7:0]              dataBusValue_ff,   // data bus out
   output logic                    dataOe_ff,         // data bus drive
   output logic                    busy_ff,           // sequence running
   output logic                    done_ff,           // sequence ended
   output logic                    waitState_ff,      // wait state active
   output logic [3:0]              step_ff,           // cycle number - 1
   output logic [15:0]             readWord_ff        // last two bytes captured
);
   // -----------------------------------------------------------------
   // parameter check
   // -----------------------------------------------------------------
   if (MUL_CYCLES < 3 || MUL_CYCLES > 16) begin : gBadMul
      $error("MUL_CYCLES must lie in 3..16");
   end
   localparam logic [3:0] MUL_LAST = 4'(MUL_CYCLES - 1);

   // -----------------------------------------------------------------
   // reset release
   // -----------------------------------------------------------------
   logic rstMeta_ff;
   logic rstSync_ff;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_ff <= 1'b0;
         rstSync_ff <= 1'b0;
      end else begin
         rstMeta_ff <= 1'b1;
         rstSync_ff <= rstMeta_ff;
      end
   end

   // -----------------------------------------------------------------
   // latched instruction context
   // -----------------------------------------------------------------
   cbs_pkg::cbs_kind_t kind_ff;
   cbs_pkg::cbs_mode_t mode_ff;
   logic               tst_ff;
   logic               accSelB_ff;
   logic [15:0]        pc_ff;
   logic [15:0]        sp_ff;
   logic [15:0]        idx_ff;
   logic [7:0]         accA_ff;
   logic [7:0]         accB_ff;
   logic [7:0]         ccr_ff;
   logic [15:0]        storeWord_ff;
   logic [7:0]         byte1_ff;
   logic [7:0]         byte2_ff;
   logic               last_ff;
   logic               cap_ff;

   // -----------------------------------------------------------------
   // sequencing
   // -----------------------------------------------------------------
   wire issueFirst = start & ~busy_ff;
   wire isWai      = (kind_ff == cbs_pkg::CBS_K_WAI);
   wire holdWait   = busy_ff & last_ff & isWai & ~wakeIn;
   wire finish     = busy_ff & last_ff & ~holdWait;
   wire advance    = busy_ff & ~last_ff;
   wire [3:0] nxt_step = advance ? 4'(step_ff + 4'h1) : step_ff;

   // operand bytes are used in the same cycle they arrive
   wire [7:0] byte1Now = (step_ff == 4'h1) ? busDin : byte1_ff;
   wire [7:0] byte2Now = (step_ff == 4'h2) ? busDin : byte2_ff;
   wire [15:0] ea;

   cbs_ea_calc uEa (
      .mode  (mode_ff),
      .byte1 (byte1Now),
      .byte2 (byte2Now),
      .idx   (idx_ff),
      .pc    (pc_ff),
      .ea    (ea)
   );

   wire [15:0] retOfs  = (mode_ff == cbs_pkg::CBS_M_INH) ? `CBS_RET_OFS_INT :
                         (mode_ff == cbs_pkg::CBS_M_EXT) ? `CBS_RET_OFS_EXT :
                         `CBS_RET_OFS_SHORT;
   wire [15:0] retAddr = pc_ff + retOfs;
   wire [3:0]  memStart = (mode_ff == cbs_pkg::CBS_M_DIR) ? `CBS_MEM_START_DIR :
                          `CBS_MEM_START;

   // -----------------------------------------------------------------
   // per-cycle micro operation
   // -----------------------------------------------------------------
   cbs_pkg::cbs_base_t uBase;
   cbs_pkg::cbs_dsel_t uDsel;
   logic signed [4:0]  uDelta;
   logic               uRw;
   logic               uCap;
   logic               uLast;
   logic [3:0]         stackIdx;
   logic [3:0]         memIdx;
   logic [4:0]         pullDelta;
   logic [4:0]         pushDelta;

   always_comb begin
      uBase     = cbs_pkg::CBS_B_PC;
      uDsel     = cbs_pkg::CBS_D_NONE;
      uDelta    = 5'sh00;
      uRw       = 1'b1;
      uCap      = 1'b0;
      uLast     = 1'b0;
      stackIdx  = 4'(nxt_step - 4'h2);
      memIdx    = 4'(nxt_step - memStart);
      pullDelta = {1'b0, stackIdx};
      pushDelta = 5'(5'h00 - {1'b0, stackIdx});
      if (nxt_step == 4'h1) begin
         uDelta = 5'sh01;
         uLast  = (kind_ff == cbs_pkg::CBS_K_SIMPLE);
      end else if (mode_ff == cbs_pkg::CBS_M_INH) begin
         case (kind_ff)
            cbs_pkg::CBS_K_ABX: begin
               uBase = cbs_pkg::CBS_B_DUMMY;
               uLast = 1'b1;
            end
            cbs_pkg::CBS_K_MUL: begin
               uBase = cbs_pkg::CBS_B_DUMMY;
               uLast = (nxt_step == MUL_LAST);
            end
            cbs_pkg::CBS_K_PUSH_ACC: begin
               uBase = cbs_pkg::CBS_B_SP;
               uRw   = 1'b0;
               uDsel = cbs_pkg::CBS_D_ACC;
               uLast = 1'b1;
            end
            cbs_pkg::CBS_K_PULL_ACC: begin
               uBase  = cbs_pkg::CBS_B_SP;
               uDelta = pullDelta;
               uCap   = (nxt_step == 4'h3);
               uLast  = (nxt_step == 4'h3);
            end
            cbs_pkg::CBS_K_PUSH_IDX: begin
               uBase  = cbs_pkg::CBS_B_SP;
               uDelta = pushDelta;
               uRw    = 1'b0;
               uDsel  = (nxt_step == 4'h2) ? cbs_pkg::CBS_D_XH : cbs_pkg::CBS_D_XL;
               uLast  = (nxt_step == 4'h3);
            end
            cbs_pkg::CBS_K_PULL_IDX, cbs_pkg::CBS_K_RTS: begin
               uBase  = cbs_pkg::CBS_B_SP;
               uDelta = pullDelta;
               uCap   = (nxt_step != 4'h2);
               uLast  = (nxt_step == `CBS_STEP_PULL_LAST);
            end
            cbs_pkg::CBS_K_RTI: begin
               uBase  = cbs_pkg::CBS_B_SP;
               uDelta = pullDelta;
               uCap   = (nxt_step != 4'h2);
               uLast  = (nxt_step == `CBS_STEP_RTI_LAST);
            end
            cbs_pkg::CBS_K_SWI, cbs_pkg::CBS_K_WAI: begin
               if (nxt_step <= `CBS_STACK_LAST) begin
                  uBase  = cbs_pkg::CBS_B_SP;
                  uDelta = pushDelta;
                  uRw    = 1'b0;
                  case (stackIdx)
                     4'h0:    uDsel = cbs_pkg::CBS_D_RETL;
                     4'h1:    uDsel = cbs_pkg::CBS_D_RETH;
                     4'h2:    uDsel = cbs_pkg::CBS_D_XL;
                     4'h3:    uDsel = cbs_pkg::CBS_D_XH;
                     4'h4:    uDsel = cbs_pkg::CBS_D_ACCA;
                     4'h5:    uDsel = cbs_pkg::CBS_D_ACCB;
                     default: uDsel = cbs_pkg::CBS_D_CCR;
                  endcase
               end else if (nxt_step == `CBS_STEP_WAIT) begin
                  uBase  = cbs_pkg::CBS_B_SP;
                  uDelta = `CBS_WAIT_SP_DELTA;
                  uLast  = (kind_ff == cbs_pkg::CBS_K_WAI);
               end else if (nxt_step == `CBS_STEP_VEC_HI) begin
                  uBase = cbs_pkg::CBS_B_VEC_HI;
                  uCap  = 1'b1;
               end else begin
                  uBase = cbs_pkg::CBS_B_VEC_LO;
                  uCap  = 1'b1;
                  uLast = 1'b1;
               end
            end
            default: begin
               uBase = cbs_pkg::CBS_B_DUMMY;
               uLast = 1'b1;
            end
         endcase
      end else if (nxt_step < memStart) begin
         // third cycle: second address byte or dummy
         if (mode_ff == cbs_pkg::CBS_M_EXT) begin
            uDelta = 5'sh02;
         end else begin
            uBase = cbs_pkg::CBS_B_DUMMY;
         end
         uLast = (kind_ff == cbs_pkg::CBS_K_JUMP) | (kind_ff == cbs_pkg::CBS_K_BRANCH);
      end else begin
         uBase = cbs_pkg::CBS_B_EA;
         case (kind_ff)
            cbs_pkg::CBS_K_READ: begin
               uCap  = 1'b1;
               uLast = 1'b1;
            end
            cbs_pkg::CBS_K_STORE: begin
               uRw   = 1'b0;
               uDsel = cbs_pkg::CBS_D_ACC;
               uLast = 1'b1;
            end
            cbs_pkg::CBS_K_LOAD16, cbs_pkg::CBS_K_STORE16: begin
               uDelta = 5'(memIdx);
               uCap   = (kind_ff == cbs_pkg::CBS_K_LOAD16);
               uRw    = (kind_ff == cbs_pkg::CBS_K_LOAD16);
               uDsel  = (kind_ff == cbs_pkg::CBS_K_LOAD16) ? cbs_pkg::CBS_D_NONE :
                        (memIdx == 4'h0) ? cbs_pkg::CBS_D_WORDH : cbs_pkg::CBS_D_WORDL;
               uLast  = (memIdx == 4'h1);
            end
            cbs_pkg::CBS_K_CMP16: begin
               if (memIdx < 4'h2) begin
                  uDelta = 5'(memIdx);
                  uCap   = 1'b1;
               end else begin
                  uBase = cbs_pkg::CBS_B_DUMMY;
                  uLast = 1'b1;
               end
            end
            cbs_pkg::CBS_K_RMW: begin
               if (memIdx == 4'h0) begin
                  uCap = 1'b1;
               end else if (memIdx == 4'h1) begin
                  uBase = cbs_pkg::CBS_B_DUMMY;
               end else if (tst_ff) begin
                  uBase = cbs_pkg::CBS_B_DUMMY;
                  uLast = 1'b1;
               end else begin
                  uRw   = 1'b0;
                  uDsel = cbs_pkg::CBS_D_NEWOP;
                  uLast = 1'b1;
               end
            end
            cbs_pkg::CBS_K_CALL: begin
               if (memIdx == 4'h1) begin
                  uBase = cbs_pkg::CBS_B_SP;
                  uRw   = 1'b0;
                  uDsel = cbs_pkg::CBS_D_RETL;
               end else if (memIdx == 4'h2) begin
                  uBase  = cbs_pkg::CBS_B_SP;
                  uDelta = 5'sh1F;
                  uRw    = 1'b0;
                  uDsel  = cbs_pkg::CBS_D_RETH;
                  uLast  = 1'b1;
               end
            end
            default: begin
               uBase = cbs_pkg::CBS_B_DUMMY;
               uLast = 1'b1;
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // address and data selection
   // -----------------------------------------------------------------
   wire [15:0] baseVal = (uBase == cbs_pkg::CBS_B_PC)     ? pc_ff :
                         (uBase == cbs_pkg::CBS_B_EA)     ? ea :
                         (uBase == cbs_pkg::CBS_B_SP)     ? sp_ff :
                         (uBase == cbs_pkg::CBS_B_VEC_HI) ? `CBS_ADDR_VEC_HI :
                         (uBase == cbs_pkg::CBS_B_VEC_LO) ? `CBS_ADDR_VEC_LO :
                         `CBS_ADDR_DUMMY;
   wire [15:0] uAddr = baseVal + {{11{uDelta[4]}}, uDelta};
   wire [7:0]  accSel = accSelB_ff ? accB_ff : accA_ff;
   wire [7:0]  uData = (uDsel == cbs_pkg::CBS_D_RETL)  ? retAddr[7:0] :
                       (uDsel == cbs_pkg::CBS_D_RETH)  ? retAddr[15:8] :
                       (uDsel == cbs_pkg::CBS_D_XL)    ? idx_ff[7:0] :
                       (uDsel == cbs_pkg::CBS_D_XH)    ? idx_ff[15:8] :
                       (uDsel == cbs_pkg::CBS_D_ACCA)  ? accA_ff :
                       (uDsel == cbs_pkg::CBS_D_ACCB)  ? accB_ff :
                       (uDsel == cbs_pkg::CBS_D_ACC)   ? accSel :
                       (uDsel == cbs_pkg::CBS_D_CCR)   ? ccr_ff :
                       (uDsel == cbs_pkg::CBS_D_WORDH) ? storeWord_ff[15:8] :
                       (uDsel == cbs_pkg::CBS_D_WORDL) ? storeWord_ff[7:0] :
                       (uDsel == cbs_pkg::CBS_D_NEWOP) ? rmwDataIn : 8'h00;

   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rstSync_ff) begin
      if (!rstSync_ff) begin
         kind_ff      <= cbs_pkg::CBS_K_SIMPLE;
         mode_ff      <= cbs_pkg::CBS_M_INH;
         tst_ff       <= 1'b0;
         accSelB_ff   <= 1'b0;
         pc_ff        <= 16'h0000;
         sp_ff        <= 16'h0000;
         idx_ff       <= 16'h0000;
         accA_ff      <= 8'h00;
         accB_ff      <= 8'h00;
         ccr_ff       <= 8'h00;
         storeWord_ff <= 16'h0000;
      end else if (issueFirst) begin
         kind_ff      <= opKind;
         mode_ff      <= addrMode;
         tst_ff       <= isTst;
         accSelB_ff   <= accSelB;
         pc_ff        <= pcIn;
         sp_ff        <= spIn;
         idx_ff       <= idxIn;
         accA_ff      <= accAIn;
         accB_ff      <= accBIn;
         ccr_ff       <= ccrIn;
         storeWord_ff <= storeWordIn;
      end
   end

   always_ff @(posedge clk_sys or negedge rstSync_ff) begin
      if (!rstSync_ff) begin
         addressBusValue_ff <= `CBS_ADDR_IDLE;
         busRw_ff           <= 1'b1;
         dataBusValue_ff    <= 8'h00;
         dataOe_ff          <= 1'b0;
         step_ff            <= 4'h0;
         last_ff            <= 1'b0;
         cap_ff             <= 1'b0;
         waitState_ff       <= 1'b0;
      end else if (issueFirst) begin
         addressBusValue_ff <= pcIn;
         busRw_ff           <= 1'b1;
         dataOe_ff          <= 1'b0;
         step_ff            <= 4'h0;
         last_ff            <= 1'b0;
         cap_ff             <= 1'b0;
      end else if (advance | holdWait) begin
         addressBusValue_ff <= uAddr;
         busRw_ff           <= uRw;
         dataBusValue_ff    <= uData;
         dataOe_ff          <= ~uRw;
         step_ff            <= nxt_step;
         last_ff            <= uLast;
         cap_ff             <= uCap;
         waitState_ff       <= isWai & (nxt_step == `CBS_STEP_WAIT);
      end else if (finish) begin
         // idle bus: harmless read of the dummy address
         addressBusValue_ff <= `CBS_ADDR_IDLE;
         busRw_ff           <= 1'b1;
         dataOe_ff          <= 1'b0;
         last_ff            <= 1'b0;
         cap_ff             <= 1'b0;
         waitState_ff       <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rstSync_ff) begin
      if (!rstSync_ff) begin
         busy_ff     <= 1'b0;
         done_ff     <= 1'b0;
         byte1_ff    <= 8'h00;
         byte2_ff    <= 8'h00;
         readWord_ff <= 16'h0000;
      end else begin
         busy_ff  <= issueFirst | (busy_ff & ~finish);
         done_ff  <= finish;
         byte1_ff <= byte1Now;
         byte2_ff <= byte2Now;
         if (busy_ff & cap_ff) begin
            readWord_ff <= {readWord_ff[7:0], busDin};
         end
      end
   end
endmodule
`default_nettype wire

// ==== sim/cbs_bus_sequencer_asserts.sv ====
// concurrent checks on the bus sequencer's top-level ports
`timescale 1ns/1ps
`default_nettype none
module cbs_seq_chk #(
   parameter int MUL_CYCLES = 10
) (
   input wire logic               clk_sys,            // core clock
   input wire logic               rst_n,              // async reset
   input wire logic               start,              // begin
   input wire cbs_pkg::cbs_kind_t opKind,             // class
   input wire logic               isTst,              // test op
   input wire logic               wakeIn,             // wait exit
   input wire logic [15:0]        spIn,               // stack
   input wire logic [15:0]        addressBusValue_ff, // address
   input wire logic               busRw_ff,           // 1 read
   input wire logic               dataOe_ff,          // drive
   input wire logic               busy_ff,            // running
   input wire logic               done_ff,            // end pulse
   input wire logic               waitState_ff        // waiting
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   logic take;
   assign take = start && !busy_ff;
   rw_drive_a: assert property (dataOe_ff == !busRw_ff)
      else $error("data drive differs from write cycle");
   idle_bus_a: assert property (!busy_ff |-> addressBusValue_ff == 16'hffff && busRw_ff)
      else $error("idle bus not a read at ffff");
   done_once_a: assert property (done_ff |=> !done_ff)
      else $error("done longer than one cycle");
   wait_read_a: assert property (
      waitState_ff |-> busRw_ff && addressBusValue_ff == spIn - 16'h0007)
      else $error("wait cycle wrong");
   wake_exit_a: assert property (waitState_ff && wakeIn |=> !waitState_ff && done_ff)
      else $error("wait not ended by wake");
   simple_len_a: assert property (
      take && opKind == cbs_pkg::CBS_K_SIMPLE |-> ##1 busRw_ff ##1 busRw_ff ##1 done_ff)
      else $error("simple op length");
   mul_dummy_a: assert property (
      take && opKind == cbs_pkg::CBS_K_MUL |->
         ##MUL_CYCLES addressBusValue_ff == 16'hffff ##1 done_ff)
      else $error("multiply length");
   tst_read_a: assert property (
      take && opKind == cbs_pkg::CBS_K_RMW && isTst |->
         ##6 addressBusValue_ff == 16'hffff && busRw_ff)
      else $error("test op wrote");
   swi_vector_a: assert property (
      take && opKind == cbs_pkg::CBS_K_SWI |->
         ##11 addressBusValue_ff == 16'hfffa ##1 addressBusValue_ff == 16'hfffb)
      else $error("vector fetch wrong");
   push_write_a: assert property (
      take && opKind == cbs_pkg::CBS_K_PUSH_ACC |-> ##3 !busRw_ff ##1 done_ff)
      else $error("push not a write");
endmodule
bind cbs_bus_sequencer cbs_seq_chk #(.MUL_CYCLES(MUL_CYCLES)) i_chk (
   .clk_sys, .rst_n, .start, .opKind, .isTst, .wakeIn, .spIn,
   .addressBusValue_ff, .busRw_ff, .dataOe_ff, .busy_ff, .done_ff, .waitState_ff);
`default_nettype wire

// ==== sim/cbs_mem_model.sv ====
// memory answering the sequencer's bus cycles
`timescale 1ns/1ps
`default_nettype none
module cbs_mem_model (
   input  wire logic [15:0] addrIn,  // address bus
   input  wire logic        rwIn,    // 1 read
   output logic [7:0]       dataOut  // read data
);
   // while the device writes, show a changing pattern, never a stale byte
   assign dataOut = rwIn ? (addrIn[7:0] ^ addrIn[15:8]) : ~addrIn[7:0];
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
// self-checking bench for the bus sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        clk_sys, rst_n, start, isTst, accSelB, wakeIn, busRw_ff, dataOe_ff;
   logic        busy_ff, done_ff, waitState_ff;
   logic [15:0] pcIn, spIn, idxIn, storeWordIn, addressBusValue_ff, readWord_ff;
   logic [7:0]  accAIn, accBIn, ccrIn, rmwDataIn, busDin, dataBusValue_ff;
   logic [3:0]  step_ff, st[17];
   logic [15:0] ab[17];
   logic [7:0]  db[17];
   logic        rw[17], dn[17];
   int          bad_count = 0, cmp_count = 0;
   cbs_pkg::cbs_kind_t opKind;
   cbs_pkg::cbs_mode_t addrMode;
   cbs_bus_sequencer i_dut (.clk_sys, .rst_n, .start, .opKind, .addrMode, .isTst, .accSelB, .pcIn,
      .spIn, .idxIn, .accAIn, .accBIn, .ccrIn, .storeWordIn, .rmwDataIn, .wakeIn, .busDin,
      .addressBusValue_ff, .busRw_ff, .dataBusValue_ff, .dataOe_ff, .busy_ff, .done_ff,
      .waitState_ff, .step_ff, .readWord_ff);
   cbs_mem_model i_mem (.addrIn(addressBusValue_ff), .rwIn(busRw_ff), .dataOut(busDin));
   function automatic logic [7:0] memByte(input logic [15:0] a);
      return a[7:0] ^ a[15:8];
   endfunction
   task automatic ck(input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %0t exp %h got %h", $time, e, g);
      end
   endtask
   // one instruction, then 16 cycles of bus trace
   task automatic go(input int k, input int m, input logic t);
      opKind <= cbs_pkg::cbs_kind_t'(k);
      addrMode <= cbs_pkg::cbs_mode_t'(m);
      isTst <= t;
      start <= 1'h1;
      @(posedge clk_sys);
      start <= 1'h0;
      for (int i = 1; i < 17; i++) begin
         #1;
         ab[i] = addressBusValue_ff;
         rw[i] = busRw_ff;
         db[i] = dataBusValue_ff;
         dn[i] = done_ff;
         st[i] = step_ff;
         @(posedge clk_sys);
      end
   endtask
   task automatic t_idx;
      go(11, 2, 1'h0);
      ck(16'hffff, ab[3]);
      ck(16'h1000 + memByte(16'h2001), ab[4]);
      ck(16'h0001, 16'(dn[5]));
      ck(16'h0031, {8'h00, readWord_ff[7:0]});
      go(14, 2, 1'h0);
      ck(16'h1022, ab[5]);
      ck(16'h0000, 16'({rw[4], rw[5]}));
      ck(16'h5eed, {db[4], db[5]});
   endtask
   task automatic t_rmw;
      go(15, 3, 1'h0);
      ck(16'h2122, ab[4]);
      ck(16'hffff, ab[5]);
      ck({16'h2122}, ab[6]);
      ck(16'h007e, {7'h0, rw[6], db[6]});
      go(15, 3, 1'h1);
      ck(16'hffff, ab[6]);
      ck(16'h0001, 16'(rw[6]));
   endtask
   task automatic t_swi;
      logic [7:0] e[7];
      e = '{8'h01, 8'h20, 8'h00, 8'h10, 8'ha1, 8'hb2, 8'hc3};
      go(9, 0, 1'h0);
      for (int i = 0; i < 7; i++) begin
         ck(16'h01f0 - 16'(i), ab[i + 3]);
         ck({8'h0, e[i]}, {7'h0, rw[i + 3], db[i + 3]});
      end
      ck(16'h01e9, ab[10]);
      ck(16'hfffb, ab[12]);
      ck(16'h000b, 16'(st[12]));
      ck(16'h0001, 16'(dn[13]));
   endtask
   task automatic t_wai;
      go(10, 0, 1'h0);
      ck(16'h01e9, ab[16]);
      #1;
      ck(16'h0001, 16'(waitState_ff));
      ck(16'h0001, 16'(busy_ff));
      @(posedge clk_sys);
      wakeIn <= 1'h1;
      for (int n = 0; n < 4 && done_ff !== 1'h1; n++) @(posedge clk_sys) #1;
      ck(16'h0001, 16'(done_ff));
      @(posedge clk_sys);
      wakeIn <= 1'h0;
   endtask
   task automatic t_call;
      go(17, 3, 1'h0);
      ck(16'h2122, ab[4]);
      ck(16'h01f0, ab[5]);
      ck(16'h2003, {db[6], db[5]});
      go(17, 4, 1'h0);
      ck(16'h2023, ab[4]);
      ck(16'h2002, {db[6], db[5]});
      accSelB <= 1'h1;
      go(2, 0, 1'h0);
      ck(16'h01f0, ab[3]);
      ck(16'h00b2, {7'h0, rw[3], db[3]});
      accSelB <= 1'h0;
      go(12, 3, 1'h0);
      ck(16'h00a1, {7'h0, rw[4], db[4]});
   endtask
   // done must pulse in the cycle right after bus cycle n
   task automatic len(input int k, input int m, input int n);
      go(k, m, 1'h0);
      ck(16'h0001, 16'(dn[n + 1]));
   endtask
   task automatic t_len;
      len(0, 0, 2);
      len(1, 0, 3);
      len(2, 0, 3);
      len(3, 0, 4);
      len(4, 0, 4);
      len(5, 0, 5);
      len(6, 0, 5);
      len(7, 0, 10);
      len(8, 0, 10);
      len(18, 3, 3);
      len(19, 4, 3);
      len(11, 3, 4);
      len(12, 3, 4);
      len(13, 3, 5);
      len(13, 2, 5);
      len(16, 2, 6);
      len(16, 3, 6);
      len(17, 2, 6);
      len(12, 1, 3);
   endtask
   task automatic report_and_stop;
      if (bad_count == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      clk_sys = 1'h0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   initial begin
      #20000;
      bad_count++;
      report_and_stop();
   end
   initial begin
      {rst_n, start, isTst, accSelB, wakeIn} = 5'h00;
      opKind = cbs_pkg::CBS_K_SIMPLE;
      addrMode = cbs_pkg::CBS_M_INH;
      {pcIn, spIn, idxIn, storeWordIn} = {16'h2000, 16'h01f0, 16'h1000, 16'h5eed};
      {accAIn, accBIn, ccrIn, rmwDataIn} = {8'ha1, 8'hb2, 8'hc3, 8'h7e};
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'h1;
      repeat (3) @(posedge clk_sys);
      t_idx();
      t_rmw();
      t_swi();
      t_wai();
      t_call();
      t_len();
      report_and_stop();
   end
endmodule
`default_nettype wire
